// ===== rtl/tap_pkg.sv
// Purpose: Shared types and constants for the memory test access port.
// Assumes: Test clock pin is sampled by the 50 MHz system clock.
// Notes: Instruction codes other than 000 and 001 and all id fields are parameters.
package tap_pkg;

	// ====================================================================
	// Controller states
	typedef enum logic [3:0] {
		TEST_RESET, RUN_IDLE, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR,
		UPD_DR, SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
	} tap_state_t;

	typedef enum logic [1:0] {SEL_BSR, SEL_ID, SEL_BYP} dr_sel_t;

	// ====================================================================
	// Register sizes
	localparam int IR_W = 3;
	localparam int BSR_W = 107;
	localparam int ID_W = 32;

	// ====================================================================
	// Instruction codes
	localparam logic [2:0] INS_EXT_TEST = 3'h0;
	localparam logic [2:0] INS_ID_READ = 3'h1;
	localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
	localparam logic [2:0] INS_SAMPLE = 3'h4;
	localparam logic [2:0] INS_BYPASS = 3'h7;
	localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;
	localparam logic IR_CAPTURE_MSB = 1'h0;

	// ====================================================================
	// Identification word fields
	localparam logic [3:0] ID_REVISION = 4'h0;
	localparam logic [15:0] ID_DEVICE = 16'h0000;
	// Vendor value is arbitrary
	localparam logic [10:0] ID_VENDOR = 11'h2a5;
	localparam logic ID_PRESENT = 1'h1;
	localparam logic [ID_W-1:0] ID_WORD = {ID_REVISION, ID_DEVICE, ID_VENDOR, ID_PRESENT};

	// ====================================================================
	// Timing
	localparam logic [2:0] RESET_TMS_EDGES = 3'h5;
	localparam logic BYPASS_CAPTURE = 1'h0;

endpackage

// ===== rtl/tap_ctrl_if.sv
// Purpose: Carries controller step, mode bit and decoded state between modules.
// Assumes: One system clock domain.
// Notes: Flags are combinational from state.
`timescale 1ns/100ps
interface tap_ctrl_if;
	import tap_pkg::*;
	logic step;
	logic tms_bit;
	tap_state_t state;
	logic in_reset;
	logic capture_dr;
	logic shift_dr;
	logic update_dr;
	logic capture_ir;
	logic shift_ir;
	logic update_ir;

	modport fsm (
		input step, tms_bit,
		output state, in_reset, capture_dr, shift_dr, update_dr, capture_ir, shift_ir, update_ir
	);
	modport core (
		output step, tms_bit,
		input state, in_reset, capture_dr, shift_dr, update_dr, capture_ir, shift_ir, update_ir
	);
endinterface

// ===== rtl/tap_fsm.sv
// Purpose: Sixteen-state test controller, advanced once per test clock rise.
// Assumes: step is a one-cycle pulse on each sampled rising test clock edge.
// Notes: Synchronous active-low reset puts it in the reset state.
`timescale 1ns/100ps
module tap_fsm
	import tap_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Controller link
	tap_ctrl_if.fsm ctl
);

	tap_state_t state;
	tap_state_t next_state;
	logic [2:0] ones_cnt;

	// ====================================================================
	// Next state
	always_comb begin
		next_state = state;
		case (state)
			TEST_RESET: next_state = ctl.tms_bit ? TEST_RESET : RUN_IDLE;
			RUN_IDLE: next_state = ctl.tms_bit ? SEL_DR : RUN_IDLE;
			SEL_DR: next_state = ctl.tms_bit ? SEL_IR : CAP_DR;
			CAP_DR: next_state = ctl.tms_bit ? EXIT1_DR : SHIFT_DR;
			SHIFT_DR: next_state = ctl.tms_bit ? EXIT1_DR : SHIFT_DR;
			EXIT1_DR: next_state = ctl.tms_bit ? UPD_DR : PAUSE_DR;
			PAUSE_DR: next_state = ctl.tms_bit ? EXIT2_DR : PAUSE_DR;
			EXIT2_DR: next_state = ctl.tms_bit ? UPD_DR : SHIFT_DR;
			UPD_DR: next_state = ctl.tms_bit ? SEL_DR : RUN_IDLE;
			SEL_IR: next_state = ctl.tms_bit ? TEST_RESET : CAP_IR;
			CAP_IR: next_state = ctl.tms_bit ? EXIT1_IR : SHIFT_IR;
			SHIFT_IR: next_state = ctl.tms_bit ? EXIT1_IR : SHIFT_IR;
			EXIT1_IR: next_state = ctl.tms_bit ? UPD_IR : PAUSE_IR;
			PAUSE_IR: next_state = ctl.tms_bit ? EXIT2_IR : PAUSE_IR;
			EXIT2_IR: next_state = ctl.tms_bit ? UPD_IR : SHIFT_IR;
			UPD_IR: next_state = ctl.tms_bit ? SEL_DR : RUN_IDLE;
			default: next_state = TEST_RESET;
		endcase
	end

	// ====================================================================
	// State register
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			state <= TEST_RESET;
		end else if (ctl.step) begin
			state <= next_state;
		end
	end

	assign ctl.state = state;
	assign ctl.in_reset = (state == TEST_RESET);
	assign ctl.capture_dr = (state == CAP_DR);
	assign ctl.shift_dr = (state == SHIFT_DR);
	assign ctl.update_dr = (state == UPD_DR);
	assign ctl.capture_ir = (state == CAP_IR);
	assign ctl.shift_ir = (state == SHIFT_IR);
	assign ctl.update_ir = (state == UPD_IR);

	// ====================================================================
	// Checks
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			ones_cnt <= 3'h0;
		end else if (ctl.step) begin
			if (!ctl.tms_bit) begin
				ones_cnt <= 3'h0;
			end else if (ones_cnt != RESET_TMS_EDGES) begin
				ones_cnt <= ones_cnt + 3'h1;
			end
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_FIVE_ONES_RESET: assert property ((ones_cnt == RESET_TMS_EDGES) |-> (state == TEST_RESET))
		else $error("five high mode edges did not reach reset");
	AST_STEP_ADVANCE: assert property ((ctl.step && state == RUN_IDLE && ctl.tms_bit) |=> (state == SEL_DR))
		else $error("controller failed to leave idle");
	AST_HOLD_NO_STEP: assert property (!ctl.step |=> $stable(state))
		else $error("state moved without a test clock rise");

endmodule

// ===== rtl/sram_boundary_scan_tap.sv
// Contract
// - Sample on rising edge, drive out on falling.
// - Five high mode edges force reset.
// - Test reset leaves memory operation alone.
// - Power-up reset floats serial output.
// - Three-bit instruction register shifts when selected.
// - Reset state loads identification-read instruction.
// - Instruction capture loads 01 in LSBs.
// - Instruction selects one data register only.
// - Input enters MSB, output leaves LSB.
// - Serial output driven only while shifting.
// - Bypass bit single, cleared by bypass.
// - Pin scan chain is 107 bits.
// - Capture loads I/O ring, shift moves it.
// - Identification read captures fixed 32-bit word.
// - All-zeros instruction acts as sample.
// - External test keeps memory outputs driven.
// - Floating sample shifts chain, floats outputs.
// - Update with sample does nothing.
// - Never drives memory inputs nor preloads.
// - Bypass places one bit in path.
// - Pulled-up inputs, idle clock keeps idle.
// - Code 000 external test, 001 id read.
// - Id word: revision, device, vendor, one.
//
// Purpose: Boundary-scan test port of a burst memory, sampling the test pins.
// Assumes: Test clock period well above four system clocks.
// Notes: Test pins pass two flops; edges found on the synchronised clock.
`timescale 1ns/100ps
module sram_boundary_scan_tap
	import tap_pkg::*;
(
	// System clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Test pins
	input wire logic tck_i,
	input wire logic tms_i,
	input wire logic tdi_i,
	output logic tdo_o,
	output logic tdo_oe_o,
	// Memory pin ring
	input wire logic [BSR_W-1:0] io_ring_i,
	output logic sram_out_hiz_o
);

	// ====================================================================
	// Pin synchronisers
	logic tck_m, tck_s, tck_d;
	logic tms_m, tms_s;
	logic tdi_m, tdi_s;
	logic [BSR_W-1:0] ring_m, ring_s;
	logic tck_rise, tck_fall;

	// an unclocked test clock produces no edges, so nothing moves
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			tck_m <= 1'h0;
			tck_s <= 1'h0;
			tck_d <= 1'h0;
			tms_m <= 1'h1;
			tms_s <= 1'h1;
			tdi_m <= 1'h1;
			tdi_s <= 1'h1;
		end else begin
			tck_m <= tck_i;
			tck_s <= tck_m;
			tck_d <= tck_s;
			tms_m <= tms_i;
			tms_s <= tms_m;
			tdi_m <= tdi_i;
			tdi_s <= tdi_m;
		end
	end

	// Ring copy is used only at chain capture, so no reset is needed on it
	always_ff @(posedge ref_clk_i) begin
		ring_m <= io_ring_i;
		ring_s <= ring_m;
	end

	assign tck_rise = tck_s && !tck_d;
	assign tck_fall = !tck_s && tck_d;

	// ====================================================================
	// Controller
	tap_ctrl_if ctl ();

	assign ctl.step = tck_rise;
	assign ctl.tms_bit = tms_s;

	tap_fsm u_fsm (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.ctl(ctl)
	);

	// ====================================================================
	// Instruction register
	logic [IR_W-1:0] ir_shift;
	logic [IR_W-1:0] tap_instruction_reg;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			ir_shift <= INS_ID_READ;
		end else if (ctl.in_reset) begin
			ir_shift <= INS_ID_READ;
		end else if (tck_rise && ctl.capture_ir) begin
			ir_shift <= {IR_CAPTURE_MSB, IR_CAPTURE_PAT};
		end else if (tck_rise && ctl.shift_ir) begin
			ir_shift <= {tdi_s, ir_shift[IR_W-1:1]};
		end
	end

	// Active code changes only at update or in test reset, so a half-shifted code never steers the chains
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			tap_instruction_reg <= INS_ID_READ;
		end else if (ctl.in_reset) begin
			tap_instruction_reg <= INS_ID_READ;
		end else if (tck_rise && ctl.update_ir) begin
			tap_instruction_reg <= ir_shift;
		end
	end

	// ====================================================================
	// Decode
	dr_sel_t dr_sel;

	always_comb begin
		case (tap_instruction_reg)
			INS_EXT_TEST: dr_sel = SEL_BSR;
			INS_SAMPLE: dr_sel = SEL_BSR;
			INS_SAMPLE_Z: dr_sel = SEL_BSR;
			INS_ID_READ: dr_sel = SEL_ID;
			// Reserved codes fall to bypass so the chain length stays defined
			default: dr_sel = SEL_BYP;
		endcase
	end

	// only floating sample floats the memory outputs, echo clocks too
	// the port reset restores the id read code, so memory drive is unaffected
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			sram_out_hiz_o <= 1'h0;
		end else begin
			sram_out_hiz_o <= (tap_instruction_reg == INS_SAMPLE_Z);
		end
	end

	// ====================================================================
	// Data registers
	// the chain only observes the ring; nothing here reaches memory inputs
	logic [BSR_W-1:0] pin_scan_chain_reg;
	logic [ID_W-1:0] identification_reg;
	logic bypass_bit_reg;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			pin_scan_chain_reg <= '0;
		end else if (tck_rise && dr_sel == SEL_BSR) begin
			if (ctl.capture_dr) begin
				pin_scan_chain_reg <= ring_s;
			end else if (ctl.shift_dr) begin
				pin_scan_chain_reg <= {tdi_s, pin_scan_chain_reg[BSR_W-1:1]};
			end
			// update leaves the chain as it stands, no preload path
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			identification_reg <= ID_WORD;
		end else if (tck_rise && dr_sel == SEL_ID) begin
			if (ctl.capture_dr) begin
				identification_reg <= ID_WORD;
			end else if (ctl.shift_dr) begin
				identification_reg <= {tdi_s, identification_reg[ID_W-1:1]};
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			bypass_bit_reg <= BYPASS_CAPTURE;
		end else if (tck_rise && dr_sel == SEL_BYP) begin
			if (ctl.capture_dr) begin
				bypass_bit_reg <= BYPASS_CAPTURE;
			end else if (ctl.shift_dr) begin
				bypass_bit_reg <= tdi_s;
			end
		end
	end

	// ====================================================================
	// Serial output, moved on falling edge only
	logic out_bit;

	always_comb begin
		if (ctl.shift_ir) begin
			out_bit = ir_shift[0];
		end else if (dr_sel == SEL_BSR) begin
			out_bit = pin_scan_chain_reg[0];
		end else if (dr_sel == SEL_ID) begin
			out_bit = identification_reg[0];
		end else begin
			out_bit = bypass_bit_reg;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			tdo_o <= 1'h0;
			tdo_oe_o <= 1'h0;
		end else if (tck_fall) begin
			tdo_o <= out_bit;
			tdo_oe_o <= ctl.shift_ir || ctl.shift_dr;
		end
	end

	// ====================================================================
	// Checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_fall_idle;
		tck_fall && !(ctl.shift_ir || ctl.shift_dr);
	endsequence

	sequence s_capture_id;
		tck_rise && ctl.capture_dr && dr_sel == SEL_ID;
	endsequence

	sequence s_shift_chain;
		tck_rise && ctl.shift_dr && dr_sel == SEL_BSR;
	endsequence

	AST_TDO_ON_FALL: assert property ((tdo_o != $past(tdo_o)) |-> $past(tck_fall))
		else $error("serial output moved away from a falling edge");
	AST_TDO_FLOAT: assert property (s_fall_idle |=> !tdo_oe_o ##1 !tdo_oe_o)
		else $error("serial output driven outside a shift state");
	AST_IR_RESET_LOAD: assert property (ctl.in_reset |=> (tap_instruction_reg == INS_ID_READ))
		else $error("reset state did not load id read");
	AST_IR_CAPTURE: assert property ((tck_rise && ctl.capture_ir) |=> (ir_shift[1:0] == IR_CAPTURE_PAT))
		else $error("instruction capture pattern wrong");
	AST_ID_CAPTURE: assert property (s_capture_id |=> (identification_reg == ID_WORD))
		else $error("id word not captured");
	AST_CHAIN_SHIFT: assert property (s_shift_chain |=> (pin_scan_chain_reg[BSR_W-1] == $past(tdi_s))
		&& (pin_scan_chain_reg[BSR_W-2:0] == $past(pin_scan_chain_reg[BSR_W-1:1])))
		else $error("chain did not shift toward the lsb");
	AST_CHAIN_CAPTURE: assert property ((tck_rise && ctl.capture_dr && dr_sel == SEL_BSR)
		|=> (pin_scan_chain_reg == $past(ring_s)))
		else $error("ring not captured");
	AST_BYPASS_CLEAR: assert property ((tck_rise && ctl.capture_dr && dr_sel == SEL_BYP) |=> !bypass_bit_reg)
		else $error("bypass bit not cleared");
	AST_FLOAT_SAMPLE: assert property ((tck_rise && ctl.update_ir && ir_shift == INS_SAMPLE_Z)
		|=> ##1 sram_out_hiz_o)
		else $error("floating sample did not float outputs");
	AST_EXTEST_DRIVE: assert property ((tap_instruction_reg == INS_EXT_TEST) |=> !sram_out_hiz_o)
		else $error("external test floated memory outputs");
	AST_UPDATE_HOLD: assert property ((tck_rise && ctl.update_dr) |=> $stable(pin_scan_chain_reg))
		else $error("update changed the chain");

	sequence s_fall_shift;
		tck_fall && (ctl.shift_ir || ctl.shift_dr);
	endsequence

	sequence s_shift_ir;
		tck_rise && ctl.shift_ir;
	endsequence

	sequence s_shift_id;
		tck_rise && ctl.shift_dr && dr_sel == SEL_ID;
	endsequence

	// Output bit must be the LSB that stood just before the fall
	AST_TDO_DRIVE: assert property (s_fall_shift |=> tdo_oe_o)
		else $error("serial output not driven while shifting");
	AST_IR_TDO: assert property ((tck_fall && ctl.shift_ir)
		|=> (tdo_o == $past(ir_shift[0])))
		else $error("instruction bit not taken from the lsb");
	AST_ID_TDO: assert property ((tck_fall && ctl.shift_dr && dr_sel == SEL_ID)
		|=> (tdo_o == $past(identification_reg[0])))
		else $error("id bit not taken from the lsb");
	AST_IR_SHIFT: assert property (s_shift_ir
		|=> (ir_shift == {$past(tdi_s), $past(ir_shift[IR_W-1:1])}))
		else $error("instruction register did not shift toward the lsb");
	AST_ID_SHIFT: assert property (s_shift_id
		|=> (identification_reg == {$past(tdi_s), $past(identification_reg[ID_W-1:1])}))
		else $error("identification_reg did not shift toward the lsb");
	AST_BYPASS_SHIFT: assert property ((tck_rise && ctl.shift_dr && dr_sel == SEL_BYP)
		|=> (bypass_bit_reg == $past(tdi_s)))
		else $error("bypass bit did not take the serial input");
	AST_ONE_CHAIN: assert property (s_shift_chain
		|=> ($stable(identification_reg) && $stable(bypass_bit_reg)))
		else $error("a second data register moved during a chain shift");
	// Checks are off during reset, so the power-up state is looked at on the release edge
	AST_RELEASE_FLOAT: assert property ($rose(rst_n_i) |-> (!tdo_oe_o && !sram_out_hiz_o))
		else $error("serial output not floating after reset");
	AST_RELEASE_IR: assert property ($rose(rst_n_i) |-> (ctl.in_reset && tap_instruction_reg == INS_ID_READ))
		else $error("reset did not restore id read");
	AST_HIZ_ONLY_FLOAT: assert property (sram_out_hiz_o |-> ($past(tap_instruction_reg) == INS_SAMPLE_Z))
		else $error("memory outputs floated by another instruction");

endmodule

// ===== testbench/tap_host_model.sv
// Purpose: Board-side test controller driving the test pins of the scan port.
// Assumes: Test clock of 160 ns, standing low between frames.
// Notes: A floating serial output is returned as z to the caller.
`timescale 1ns/100ps
module tap_host_model (
	// System clock, used only to pace the pins
	input wire logic ref_clk_i,
	// Test pins seen from the board
	input wire logic tdo_i,
	input wire logic tdo_oe_i,
	output logic tck_o,
	output logic tms_o,
	output logic tdi_o
);
	// ====================================================================
	// Pin drivers
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b1;
	end

	// One test clock period: set pins in the low phase, read the output just before the rise
	task step(input logic m, input logic d, output logic q);
		@(posedge ref_clk_i);
		#1;
		tms_o = m;
		tdi_o = d;
		repeat (3) @(posedge ref_clk_i);
		#1;
		q = tdo_oe_i ? tdo_i : 1'bz;
		tck_o = 1'b1;
		repeat (4) @(posedge ref_clk_i);
		#1;
		tck_o = 1'b0;
		tdi_o = 1'b1;
	endtask

	// Walk the controller with a mode pattern sent LSB first
	task go(input logic [7:0] p, input int n);
		int i;
		logic q;
		for (i = 0; i < n; i++) begin
			step(p[i], 1'b1, q);
		end
	endtask

	// Shift n bits LSB first, leaving the shift state on the last one
	task shift(input int n, input logic [127:0] d, output logic [127:0] o);
		int i;
		logic q;
		o = '0;
		for (i = 0; i < n; i++) begin
			step(i == n - 1, d[i], q);
			o[i] = q;
		end
	endtask
endmodule

// ===== testbench/testbench.sv
// Purpose: Self-checking bench for the memory scan port.
// Assumes: Only the five implemented instruction codes are ever loaded.
// Notes: Random data from a 16-bit shift register seeded with 85.
`timescale 1ns/100ps
module testbench;
	import tap_pkg::*;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic tck, tms, tdi, tdo, tdo_oe, hiz, q;
	logic [BSR_W-1:0] ring = '0;
	logic [15:0] seed = 16'h0055;
	logic [127:0] din, dout, tmp;
	logic [2:0] cap;
	logic [2:0] codes [4] = '{INS_EXT_TEST, INS_SAMPLE, INS_SAMPLE_Z, INS_BYPASS};
	int n_mismatch = 0;
	int n_tests = 0;

	initial forever #10 ref_clk_i = ~ref_clk_i;

	sram_boundary_scan_tap dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .tck_i(tck), .tms_i(tms),
		.tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .io_ring_i(ring), .sram_out_hiz_o(hiz));
	tap_host_model host (.ref_clk_i(ref_clk_i), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck),
		.tms_o(tms), .tdi_o(tdi));

	// ====================================================================
	// Expectations and checks
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task rnd(output logic [127:0] v);
		int k;
		for (k = 0; k < 8; k++) begin
			seed = lfsr(seed);
			v[k*16 +: 16] = seed;
		end
	endtask

	// Captured word leaves first, then the bits fed in, delayed by the register length
	function automatic logic [127:0] exp_dr(input logic [2:0] code, input logic [127:0] d);
		int w;
		logic [127:0] c;
		case (code)
			INS_ID_READ: begin
				w = ID_W;
				c = 128'(ID_WORD);
			end
			INS_BYPASS: begin
				w = 1;
				c = '0;
			end
			default: begin
				w = BSR_W;
				c = 128'(ring);
			end
		endcase
		return (c & ((128'h1 << w) - 128'h1)) | (d << w);
	endfunction

	task chk1(input logic g, input logic e);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task chkv(input logic [127:0] g, input logic [127:0] e, input int n);
		logic [127:0] m;
		m = (128'h1 << n) - 128'h1;
		n_tests++;
		if ((g & m) !== (e & m)) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g & m, e & m);
		end
	endtask

	task load_ir(input logic [2:0] c, output logic [2:0] o);
		host.go(8'h03, 4);
		host.shift(3, 128'(c), tmp);
		o = tmp[2:0];
		host.go(8'h01, 2);
	endtask

	// After leaving shift the output must float on the following fall
	task scan_dr(input int n, input logic [127:0] d, output logic [127:0] o);
		host.go(8'h01, 3);
		host.shift(n, d, o);
		host.step(1'b1, 1'b1, q);
		chk1(q, 1'bz);
		host.step(1'b0, 1'b1, q);
	endtask

	task power_reset();
		@(posedge ref_clk_i);
		#1;
		rst_n_i = 1'b0;
		repeat (16) @(posedge ref_clk_i);
		#1;
		rst_n_i = 1'b1;
		repeat (3) @(posedge ref_clk_i);
		#1;
		chk1(tdo_oe, 1'b0);
		chk1(hiz, 1'b0);
		host.go(8'h00, 1);
		rnd(din);
		scan_dr(64, din, dout);
		chkv(dout, exp_dr(INS_ID_READ, din), 64);
	endtask

	task results();
		$display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ====================================================================
	// Timeout: about 720 test clock periods are needed
	initial begin
		repeat (30000) @(posedge ref_clk_i);
		n_mismatch++;
		results();
	end

	// ====================================================================
	// Main sequence
	initial begin
		power_reset();
		for (int i = 0; i < 4; i++) begin
			rnd(tmp);
			ring = tmp[BSR_W-1:0];
			rnd(din);
			load_ir(codes[i], cap);
			chkv(128'(cap), 128'h1, 3);
			chk1(hiz, codes[i] == INS_SAMPLE_Z);
			scan_dr(115, din, dout);
			chkv(dout, exp_dr(codes[i], din), 115);
			chk1(hiz, codes[i] == INS_SAMPLE_Z);
		end
		// Five high mode rises from the middle of a shift
		load_ir(INS_SAMPLE_Z, cap);
		host.go(8'h01, 3);
		host.go(8'h1f, 5);
		host.step(1'b0, 1'b1, q);
		chk1(hiz, 1'b0);
		rnd(din);
		scan_dr(32, din, dout);
		chkv(dout, exp_dr(INS_ID_READ, din), 32);
		// System reset in mid-run, floating instruction active
		load_ir(INS_SAMPLE_Z, cap);
		chk1(hiz, 1'b1);
		power_reset();
		results();
	end
endmodule
